// File: rtl/mio_pin_sync.sv
/*
 * Three-stage input synchroniser for the port pins.
 * Assumes the pins are asynchronous to core_clk; a bit is accepted
 * once the second and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none
module mio_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;

    // Pins idle high (pull-ups), so reset to ones
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_q <= '1;
            stage2_q <= '1;
            stage3_q <= '1;
        end else begin
            stage1_q <= pin_raw;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Per-bit acceptance, filters a single-cycle disagreement
    for (genvar b = 0; b < WIDTH; b++) begin : g_accept
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                level_q[b] <= 1'b1;
            end else if (stage2_q[b] == stage3_q[b]) begin
                level_q[b] <= stage3_q[b];
            end
        end
    end

    assign pin_level = level_q;
endmodule
`default_nettype wire

// File: rtl/mio_pkg.sv
/*
 * Constants for the five-port I/O block: port numbering, widths,
 * reset values and synchroniser depth.
 * Assumes nothing about its surroundings.
 */
package mio_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned PORT4_W = 2;
    localparam int unsigned NUM_PORTS = 5;
    localparam int unsigned PIN_TOTAL = 4 * PORT_W + PORT4_W;
    localparam int unsigned SYNC_STAGES = 3;
    // Port select codes on the CPU side
    localparam logic [2:0] SEL_P0 = 3'h0;
    localparam logic [2:0] SEL_P1 = 3'h1;
    localparam logic [2:0] SEL_P2 = 3'h2;
    localparam logic [2:0] SEL_P3 = 3'h3;
    localparam logic [2:0] SEL_P4 = 3'h4;
    // Every latch comes out of reset at all ones
    localparam logic [7:0] LATCH_RST = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    // Port 1 bit positions
    localparam int unsigned P1_T2_CLK = 0;
    localparam int unsigned P1_T2_TRIG = 1;
    localparam int unsigned P1_ARR_CLK = 2;
    localparam int unsigned P1_CAP_LO = 3;
    localparam int unsigned NUM_CAP = 5;
    // Port 3 bit positions
    localparam int unsigned P3_RXD = 0;
    localparam int unsigned P3_TXD = 1;
    localparam int unsigned P3_IRQ0 = 2;
    localparam int unsigned P3_IRQ1 = 3;
    localparam int unsigned P3_CNT0 = 4;
    localparam int unsigned P3_CNT1 = 5;
    localparam int unsigned P3_WR = 6;
    localparam int unsigned P3_RD = 7;
    // Port 4 bit positions
    localparam int unsigned P4_CAN_TX = 0;
    localparam int unsigned P4_CAN_RX = 1;
    // Offsets of each port in the flattened pin vector
    localparam int unsigned OFS_P0 = 0;
    localparam int unsigned OFS_P1 = 8;
    localparam int unsigned OFS_P2 = 16;
    localparam int unsigned OFS_P3 = 24;
    localparam int unsigned OFS_P4 = 32;
endpackage

// File: rtl/mio_ports.sv
/*
 * Five microcontroller I/O ports: latches, pin drivers with the
 * external bus multiplex on ports 0 and 2, and alternate functions.
 * Assumes CPU and peripheral signals are on core_clk; pins are
 * asynchronous and pass through mio_pin_sync.
 */
`timescale 1ns/10ps
`default_nettype none
module mio_ports (
    input wire logic core_clk,
    input wire logic reset,
    // CPU side
    input wire logic cpu_wr_en,
    input wire logic cpu_rd_en,
    input wire logic cpu_rd_latch,
    input wire logic [2:0] cpu_port_sel,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    // External bus sequencer
    input wire logic bus_addr_phase,
    input wire logic bus_data_out,
    input wire logic bus_data_in,
    input wire logic bus_fetch,
    input wire logic bus_move_ptr16,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr_stb,
    input wire logic bus_rd_stb,
    output logic [7:0] bus_rdata,
    input wire logic verify_mode,
    input wire logic [7:0] verify_code,
    // Peripheral alternate functions
    input wire logic [7:0] analog_pin_select,
    input wire logic [4:0] capture_out,
    input wire logic [4:0] capture_out_en,
    input wire logic serial_tx_en,
    input wire logic serial_txd,
    input wire logic serial_sync_mode,
    input wire logic serial_sync_dout,
    input wire logic serial_sync_dout_en,
    input wire logic can_transmit_line,
    output logic timer2_clock_in,
    output logic timer2_trigger_in,
    output logic array_ext_clock_in,
    output logic [4:0] capture_module_io,
    output logic serial_rxd,
    output logic ext_irq_line_zero,
    output logic ext_irq_line_one,
    output logic counter0_input,
    output logic counter1_input,
    output logic can_receive_line,
    // Pins: input, output value, enable (high while driving)
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p1_pullup_en,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe,
    input wire logic [1:0] p4_in,
    output logic [1:0] p4_out,
    output logic [1:0] p4_oe
);
    logic [7:0] latch_q [mio_pkg::NUM_PORTS];
    logic [mio_pkg::PIN_TOTAL-1:0] pin_level;
    logic [7:0] lvl0, lvl1, lvl2, lvl3;
    logic [1:0] lvl4;
    logic [7:0] p0_out_d, p0_oe_d, p2_out_d, p2_oe_d;
    logic [7:0] p1_val, p3_val;
    logic [1:0] p4_val;
    logic [7:0] rd_pin, rd_latch;
    logic [7:0] cpu_rdata_q, bus_rdata_q;
    logic [7:0] p0_out_q, p0_oe_q, p1_out_q, p1_oe_q, p1_pu_q;
    logic [7:0] p2_out_q, p2_oe_q, p3_out_q, p3_oe_q;
    logic [1:0] p4_out_q, p4_oe_q;
    logic [4:0] cap_in_q;
    logic t2c_q, t2t_q, arr_q, rxd_q, irq0_q, irq1_q, c0_q, c1_q, canrx_q;

    mio_pin_sync #(
        .WIDTH(mio_pkg::PIN_TOTAL)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_raw({p4_in, p3_in, p2_in, p1_in, p0_in}),
        .pin_level(pin_level)
    );

    assign lvl0 = pin_level[mio_pkg::OFS_P0 +: 8];
    assign lvl1 = pin_level[mio_pkg::OFS_P1 +: 8];
    assign lvl2 = pin_level[mio_pkg::OFS_P2 +: 8];
    assign lvl3 = pin_level[mio_pkg::OFS_P3 +: 8];
    assign lvl4 = pin_level[mio_pkg::OFS_P4 +: 2];

    // Latches: ones at reset, CPU write on the write cycle
    for (genvar p = 0; p < mio_pkg::NUM_PORTS; p++) begin : g_latch
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                latch_q[p] <= mio_pkg::LATCH_RST;
            end else if (cpu_wr_en && cpu_port_sel == 3'(p)) begin
                latch_q[p] <= cpu_wdata;
            end
        end
    end

    // Port 0: address and write-data phases drive hard, otherwise open drain
    always_comb begin
        p0_out_d = mio_pkg::ALL_ZERO;
        p0_oe_d = ~latch_q[0];
        if (bus_addr_phase) begin
            p0_out_d = bus_addr[7:0];
            p0_oe_d = 8'hFF;
        end else if (bus_data_out) begin
            p0_out_d = bus_wdata;
            p0_oe_d = 8'hFF;
        end else if (bus_data_in) begin
            p0_oe_d = mio_pkg::ALL_ZERO;
        end else if (verify_mode) begin
            // Only zeros driven; ones rely on outside pull-ups
            p0_oe_d = ~verify_code;
        end
    end

    // Port 2: high address byte or latch contents
    always_comb begin
        if (bus_fetch || bus_move_ptr16) begin
            p2_out_d = bus_addr[15:8];
            p2_oe_d = 8'hFF;
        end else begin
            // Indirect-index moves fall through to the latch
            p2_out_d = latch_q[2];
            p2_oe_d = ~latch_q[2];
        end
    end

    // Port 1: module outputs ANDed with the latch
    always_comb begin
        p1_val = latch_q[1];
        for (int m = 0; m < mio_pkg::NUM_CAP; m++) begin
            if (capture_out_en[m]) begin
                p1_val[mio_pkg::P1_CAP_LO + m] =
                    latch_q[1][mio_pkg::P1_CAP_LO + m] & capture_out[m];
            end
        end
    end

    // Port 3: latch gates alternates, transmit and write exempt
    always_comb begin
        p3_val = latch_q[3];
        if (serial_sync_mode && serial_sync_dout_en) begin
            p3_val[mio_pkg::P3_RXD] =
                latch_q[3][mio_pkg::P3_RXD] & serial_sync_dout;
        end
        if (serial_tx_en) begin
            // Transmit and shift clock bypass the latch
            p3_val[mio_pkg::P3_TXD] = serial_txd;
        end
        if (bus_wr_stb) begin
            p3_val[mio_pkg::P3_WR] = 1'b0;
        end
        p3_val[mio_pkg::P3_RD] =
            latch_q[3][mio_pkg::P3_RD] & ~bus_rd_stb;
    end

    always_comb begin
        p4_val = latch_q[4][1:0];
        p4_val[mio_pkg::P4_CAN_TX] =
            latch_q[4][mio_pkg::P4_CAN_TX] & can_transmit_line;
    end

    // Pin registers; quasi-bidirectional pins drive low only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            p0_out_q <= mio_pkg::ALL_ZERO;
            p0_oe_q <= mio_pkg::ALL_ZERO;
            p1_out_q <= mio_pkg::LATCH_RST;
            p1_oe_q <= mio_pkg::ALL_ZERO;
            p1_pu_q <= mio_pkg::LATCH_RST;
            p2_out_q <= mio_pkg::LATCH_RST;
            p2_oe_q <= mio_pkg::ALL_ZERO;
            p3_out_q <= mio_pkg::LATCH_RST;
            p3_oe_q <= mio_pkg::ALL_ZERO;
            p4_out_q <= 2'h3;
            p4_oe_q <= 2'h0;
        end else begin
            p0_out_q <= p0_out_d;
            p0_oe_q <= p0_oe_d;
            p1_out_q <= p1_val;
            p1_oe_q <= ~p1_val;
            p1_pu_q <= ~analog_pin_select;
            p2_out_q <= p2_out_d;
            p2_oe_q <= p2_oe_d;
            p3_out_q <= p3_val;
            p3_oe_q <= ~p3_val;
            p4_out_q <= p4_val;
            p4_oe_q <= ~p4_val;
        end
    end

    // Alternate inputs to peripherals
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            t2c_q <= 1'b1;
            t2t_q <= 1'b1;
            arr_q <= 1'b1;
            cap_in_q <= 5'h1F;
            rxd_q <= 1'b1;
            irq0_q <= 1'b1;
            irq1_q <= 1'b1;
            c0_q <= 1'b1;
            c1_q <= 1'b1;
            canrx_q <= 1'b1;
        end else begin
            t2c_q <= lvl1[mio_pkg::P1_T2_CLK];
            t2t_q <= lvl1[mio_pkg::P1_T2_TRIG];
            arr_q <= lvl1[mio_pkg::P1_ARR_CLK];
            cap_in_q <= lvl1[mio_pkg::P1_CAP_LO +: mio_pkg::NUM_CAP];
            // A zero latch holds the pin low, so gate it away
            rxd_q <= lvl3[mio_pkg::P3_RXD]
                & latch_q[3][mio_pkg::P3_RXD];
            irq0_q <= lvl3[mio_pkg::P3_IRQ0] & latch_q[3][mio_pkg::P3_IRQ0];
            irq1_q <= lvl3[mio_pkg::P3_IRQ1] & latch_q[3][mio_pkg::P3_IRQ1];
            c0_q <= lvl3[mio_pkg::P3_CNT0] & latch_q[3][mio_pkg::P3_CNT0];
            c1_q <= lvl3[mio_pkg::P3_CNT1] & latch_q[3][mio_pkg::P3_CNT1];
            canrx_q <= lvl4[mio_pkg::P4_CAN_RX]
                & latch_q[4][mio_pkg::P4_CAN_RX];
        end
    end

    // CPU read path: pins normally, latch for read-modify-write
    always_comb begin
        rd_pin = mio_pkg::ALL_ZERO;
        rd_latch = mio_pkg::ALL_ZERO;
        unique case (cpu_port_sel)
            mio_pkg::SEL_P0: begin
                rd_pin = lvl0;
                rd_latch = latch_q[0];
            end
            mio_pkg::SEL_P1: begin
                rd_pin = lvl1;
                rd_latch = latch_q[1];
            end
            mio_pkg::SEL_P2: begin
                rd_pin = lvl2;
                rd_latch = latch_q[2];
            end
            mio_pkg::SEL_P3: begin
                rd_pin = lvl3;
                rd_latch = latch_q[3];
            end
            mio_pkg::SEL_P4: begin
                rd_pin = {6'h00, lvl4};
                rd_latch = {6'h00, latch_q[4][1:0]};
            end
            default: begin
                rd_pin = mio_pkg::ALL_ZERO;
                rd_latch = mio_pkg::ALL_ZERO;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cpu_rdata_q <= mio_pkg::ALL_ZERO;
        end else if (cpu_rd_en) begin
            cpu_rdata_q <= cpu_rd_latch ? rd_latch : rd_pin;
        end
    end

    // Data byte from external memory
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bus_rdata_q <= mio_pkg::ALL_ZERO;
        end else if (bus_data_in) begin
            bus_rdata_q <= lvl0;
        end
    end

    assign cpu_rdata = cpu_rdata_q;
    assign bus_rdata = bus_rdata_q;
    assign p0_out = p0_out_q;
    assign p0_oe = p0_oe_q;
    assign p1_out = p1_out_q;
    assign p1_oe = p1_oe_q;
    assign p1_pullup_en = p1_pu_q;
    assign p2_out = p2_out_q;
    assign p2_oe = p2_oe_q;
    assign p3_out = p3_out_q;
    assign p3_oe = p3_oe_q;
    assign p4_out = p4_out_q;
    assign p4_oe = p4_oe_q;
    assign timer2_clock_in = t2c_q;
    assign timer2_trigger_in = t2t_q;
    assign array_ext_clock_in = arr_q;
    assign capture_module_io = cap_in_q;
    assign serial_rxd = rxd_q;
    assign ext_irq_line_zero = irq0_q;
    assign ext_irq_line_one = irq1_q;
    assign counter0_input = c0_q;
    assign counter1_input = c1_q;
    assign can_receive_line = canrx_q;
endmodule
`default_nettype wire

// File: tb/mio_ext_mem.sv
/* External memory and pin loads on the far side of the ports.
   Assumes ext_low from the bench pulls chosen pins low. */
`timescale 1ns/10ps
`default_nettype none
module mio_ext_mem (
    input wire logic core_clk,
    input wire logic [mio_pkg::PIN_TOTAL-1:0] ext_low,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p1_pullup_en,
    input wire logic [7:0] p2_out,
    input wire logic [7:0] p2_oe,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [1:0] p4_out,
    input wire logic [1:0] p4_oe,
    output logic [7:0] p0_in,
    output logic [7:0] p1_in,
    output logic [7:0] p2_in,
    output logic [7:0] p3_in,
    output logic [1:0] p4_in,
    output logic [7:0] mem_q
);
    // Floating lines wander so a stale value is never read as valid
    logic pat_q = 1'b0;
    logic [7:0] mem_r = 8'h00;
    logic wr_low;
    logic rd_low;
    assign wr_low = p3_oe[6] & ~p3_out[6];
    assign rd_low = p3_oe[7] & ~p3_out[7];
    assign mem_q = mem_r;
    always_ff @(posedge core_clk) begin
        pat_q <= ~pat_q;
        if (wr_low) begin
            mem_r <= p0_in;
        end
    end
    // No pull-ups on port 0; memory drives it only under read strobe
    assign p0_in = (p0_oe & p0_out) |
        (~p0_oe & (rd_low ? mem_r : {8{pat_q}}));
    assign p1_in = (p1_oe & p1_out) | (~p1_oe &
        ~ext_low[mio_pkg::OFS_P1 +: 8] & (p1_pullup_en | {8{pat_q}}));
    assign p2_in = (p2_oe & p2_out) | (~p2_oe & ~ext_low[16 +: 8]);
    assign p3_in = (p3_oe & p3_out) | (~p3_oe & ~ext_low[24 +: 8]);
    assign p4_in = (p4_oe & p4_out) | (~p4_oe & ~ext_low[32 +: 2]);
endmodule
`default_nettype wire

// File: tb/mio_ports_monitor.sv
/* Concurrent checks on the port block's pins and bus multiplex.
   Assumes one clock domain, bound onto mio_ports. */
`timescale 1ns/10ps
`default_nettype none
module mio_ports_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic bus_addr_phase,
    input wire logic bus_data_out,
    input wire logic bus_data_in,
    input wire logic bus_fetch,
    input wire logic bus_move_ptr16,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr_stb,
    input wire logic verify_mode,
    input wire logic [7:0] verify_code,
    input wire logic [7:0] analog_pin_select,
    input wire logic cpu_rd_en,
    input wire logic [7:0] cpu_rdata,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p1_pullup_en,
    input wire logic [7:0] p2_out,
    input wire logic [7:0] p2_oe,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    reset_idle_a: assert property (
        $fell(reset) |-> (p0_oe | p1_oe | p2_oe | p3_oe) == 8'h00)
        else $error("pins driven right after reset");
    addr_drive_a: assert property (
        bus_addr_phase |=> p0_oe == 8'hFF && p0_out == $past(bus_addr[7:0]))
        else $error("low address not on port 0");
    data_drive_a: assert property (
        bus_data_out && !bus_addr_phase
        |=> p0_oe == 8'hFF && p0_out == $past(bus_wdata))
        else $error("write data not on port 0");
    verify_code_a: assert property (
        verify_mode && !bus_addr_phase && !bus_data_out && !bus_data_in
        |=> p0_out == 8'h00 && p0_oe == ~$past(verify_code))
        else $error("code byte not shown on port 0");
    high_addr_a: assert property (
        bus_fetch || bus_move_ptr16
        |=> p2_oe == 8'hFF && p2_out == $past(bus_addr[15:8]))
        else $error("high address not on port 2");
    quasi_drive_a: assert property (
        p1_oe == ~p1_out)
        else $error("port 1 drives a one strongly");
    analog_pull_a: assert property (
        (p1_pullup_en & $past(analog_pin_select)) == 8'h00)
        else $error("pull-up left on an analog pin");
    wr_strobe_a: assert property (
        bus_wr_stb |=> p3_oe[mio_pkg::P3_WR] && !p3_out[mio_pkg::P3_WR])
        else $error("write strobe not driven low");
    rdata_hold_a: assert property (
        !cpu_rd_en |=> $stable(cpu_rdata))
        else $error("read data changed without a read");
endmodule
bind mio_ports mio_ports_monitor u_mon (
    .core_clk, .reset, .bus_addr_phase, .bus_data_out, .bus_data_in,
    .bus_fetch, .bus_move_ptr16, .bus_addr, .bus_wdata, .bus_wr_stb,
    .verify_mode, .verify_code, .analog_pin_select, .cpu_rd_en,
    .cpu_rdata, .p0_out, .p0_oe, .p1_out, .p1_oe, .p1_pullup_en,
    .p2_out, .p2_oe, .p3_out, .p3_oe
);
`default_nettype wire

// File: tb/test_mio_ports.sv
/* Self-checking bench for mio_ports with the external memory model.
   Assumes 250 MHz core_clk and inputs driven 1 ns after each edge. */
`timescale 1ns/10ps
`default_nettype none
module test_mio_ports;
    logic core_clk = 1'b0, reset = 1'b1;
    logic cpu_wr_en = 0, cpu_rd_en = 0, cpu_rd_latch = 0, verify_mode = 0;
    logic bus_addr_phase = 0, bus_data_out = 0, bus_data_in = 0;
    logic bus_fetch = 0, bus_move_ptr16 = 0, bus_wr_stb = 0, bus_rd_stb = 0;
    logic serial_tx_en = 0, serial_txd = 0, serial_sync_mode = 0;
    logic serial_sync_dout = 0, serial_sync_dout_en = 0;
    logic can_transmit_line = 1, timer2_clock_in, timer2_trigger_in;
    logic array_ext_clock_in, serial_rxd, ext_irq_line_zero;
    logic ext_irq_line_one, counter0_input, counter1_input;
    logic can_receive_line;
    logic [2:0] cpu_port_sel = 0;
    logic [7:0] cpu_wdata = 0, verify_code = 0, analog_pin_select = 0;
    logic [7:0] cpu_rdata, bus_rdata, bus_wdata = 0, mem_q;
    logic [15:0] bus_addr = 0;
    logic [4:0] capture_out = 0, capture_out_en = 0, capture_module_io;
    logic [7:0] p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, p1_pullup_en;
    logic [7:0] p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe;
    logic [1:0] p4_in, p4_out, p4_oe;
    logic [33:0] ext_low = 0;
    int errors = 0, samples_checked = 0;
    always #2 core_clk = ~core_clk;
    mio_ports u_dut (.core_clk, .reset, .cpu_wr_en, .cpu_rd_en,
        .cpu_rd_latch, .cpu_port_sel, .cpu_wdata, .cpu_rdata,
        .bus_addr_phase, .bus_data_out, .bus_data_in, .bus_fetch,
        .bus_move_ptr16, .bus_addr, .bus_wdata, .bus_wr_stb, .bus_rd_stb,
        .bus_rdata, .verify_mode, .verify_code, .analog_pin_select,
        .capture_out, .capture_out_en, .serial_tx_en, .serial_txd,
        .serial_sync_mode, .serial_sync_dout, .serial_sync_dout_en,
        .can_transmit_line, .timer2_clock_in, .timer2_trigger_in,
        .array_ext_clock_in, .capture_module_io, .serial_rxd,
        .ext_irq_line_zero, .ext_irq_line_one, .counter0_input,
        .counter1_input, .can_receive_line, .p0_in, .p0_out, .p0_oe,
        .p1_in, .p1_out, .p1_oe, .p1_pullup_en, .p2_in, .p2_out, .p2_oe,
        .p3_in, .p3_out, .p3_oe, .p4_in, .p4_out, .p4_oe);
    mio_ext_mem u_mem (.core_clk, .ext_low, .p0_out, .p0_oe, .p1_out,
        .p1_oe, .p1_pullup_en, .p2_out, .p2_oe, .p3_out, .p3_oe, .p4_out,
        .p4_oe, .p0_in, .p1_in, .p2_in, .p3_in, .p4_in, .mem_q);
    task automatic report_and_stop();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        cpu_wr_en = 1'b1;
        cpu_port_sel = sel;
        cpu_wdata = d;
        tick(1);
        cpu_wr_en = 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [2:0] sel, input logic lat,
                          input logic [7:0] exp);
        cpu_rd_en = 1'b1;
        cpu_rd_latch = lat;
        cpu_port_sel = sel;
        tick(1);
        cpu_rd_en = 1'b0;
        chk("cpu_rdata", exp, cpu_rdata);
        // Idle edge so back-to-back reads never re-raise in one step
        tick(1);
    endtask
    task automatic t_reset();
        for (int s = 0; s < 8; s++)
            rd_chk(3'(s), 1'b1,
                s < 4 ? 8'hFF : (s == 4 ? 8'h03 : 8'h00));
        chk("p1_out", 8'hFF, p1_out);
    endtask
    task automatic t_pins();
        wr(mio_pkg::SEL_P1, 8'h5A);
        rd_chk(mio_pkg::SEL_P1, 1'b1, 8'h5A);
        chk("p1_oe", 8'hA5, p1_oe);
        tick(5);
        rd_chk(mio_pkg::SEL_P1, 1'b0, 8'h5A);
        ext_low[16 +: 8] = 8'hFF;
        tick(5);
        rd_chk(mio_pkg::SEL_P2, 1'b0, 8'h00);
        rd_chk(mio_pkg::SEL_P2, 1'b1, 8'hFF);
        ext_low = 0;
        wr(mio_pkg::SEL_P1, 8'hFF);
    endtask
    task automatic t_port0();
        chk("p0_oe", 8'h00, p0_oe);
        wr(mio_pkg::SEL_P0, 8'h00);
        chk("p0_oe", 8'hFF, p0_oe);
        wr(mio_pkg::SEL_P0, 8'hFF);
        verify_mode = 1'b1;
        verify_code = 8'h96;
        tick(1);
        chk("p0_oe", 8'h69, p0_oe);
        chk("p0_out", 8'h00, p0_out);
        verify_mode = 1'b0;
    endtask
    task automatic t_bus();
        wr(mio_pkg::SEL_P2, 8'h77);
        bus_addr = 16'h12A5;
        bus_addr_phase = 1'b1;
        bus_move_ptr16 = 1'b1;
        tick(1);
        chk("p0_out", 8'hA5, p0_out);
        chk("p2_out", 8'h12, p2_out);
        bus_addr_phase = 1'b0;
        bus_data_out = 1'b1;
        bus_wdata = 8'h3C;
        bus_wr_stb = 1'b1;
        tick(1);
        chk("p0_out", 8'h3C, p0_out);
        chk("write strobe", 8'h00, {7'h00, p3_out[6]});
        tick(1);
        bus_data_out = 1'b0;
        bus_wr_stb = 1'b0;
        bus_move_ptr16 = 1'b0;
        chk("mem_q", 8'h3C, mem_q);
        tick(1);
        chk("p2_out", 8'h77, p2_out);
        bus_data_in = 1'b1;
        bus_rd_stb = 1'b1;
        tick(6);
        chk("bus_rdata", 8'h3C, bus_rdata);
        chk("read strobe", 8'h00, {7'h00, p3_out[7]});
        bus_data_in = 1'b0;
        bus_rd_stb = 1'b0;
    endtask
    task automatic t_port3();
        ext_low[24 +: 8] = 8'h24;
        tick(5);
        chk("port 3 inputs", 8'h16,
            {3'h0, serial_rxd, ext_irq_line_zero,
            ext_irq_line_one, counter0_input, counter1_input});
        ext_low = 0;
        wr(mio_pkg::SEL_P3, 8'hFD);
        serial_tx_en = 1'b1;
        serial_txd = 1'b1;
        tick(1);
        chk("txd pin", 8'h01, {7'h00, p3_out[1]});
        serial_sync_mode = 1'b1;
        serial_sync_dout_en = 1'b1;
        serial_txd = 1'b0;
        tick(1);
        chk("sync pins", 8'h00, {6'h00, p3_out[1:0]});
        serial_sync_mode = 1'b0;
        serial_sync_dout_en = 1'b0;
        serial_tx_en = 1'b0;
        wr(mio_pkg::SEL_P3, 8'hFF);
    endtask
    task automatic t_port1_4();
        analog_pin_select = 8'h0F;
        tick(1);
        chk("p1_pullup_en", 8'hF0, p1_pullup_en);
        analog_pin_select = 8'h00;
        ext_low[8 +: 8] = 8'h55;
        ext_low[33] = 1'b1;
        can_transmit_line = 1'b0;
        tick(5);
        chk("port 1 inputs", 8'hAA,
            {capture_module_io, array_ext_clock_in,
            timer2_trigger_in, timer2_clock_in});
        chk("can pins", 8'h00,
            {6'h00, can_receive_line, p4_out[0]});
        chk("p4_oe", 8'h01, {6'h00, p4_oe});
        ext_low = 0;
        can_transmit_line = 1'b1;
        capture_out_en = 5'h01;
        tick(1);
        chk("p1_out", 8'hF7, p1_out);
        capture_out_en = 5'h00;
    endtask
    initial begin
        tick(2);
        reset = 1'b0;
        t_reset();
        t_pins();
        t_port0();
        t_bus();
        t_port3();
        t_port1_4();
        report_and_stop();
    end
    initial begin
        #20000;
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
